// ### rtl/tx_event_interrupt_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tx_event_interrupt_logic
  import tx_event_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // asynchronous sources
  input  wire logic                  hot_plug_sense_in,
  input  wire logic                  rx_sense_in,
  input  wire logic                  vsync_in,
  input  wire logic [NUM_GPIO-1:0]   gpio_pin_in,
  // same-clock sources
  input  wire logic                  power_down,
  input  wire logic                  audio_fmt_err,
  input  wire logic                  auth_err,
  input  wire logic [FIFO_ST_W-1:0]  ddc_fifo_status,
  input  wire logic                  ddc_xfer_done,
  input  wire logic                  ddc_fifo_full,
  // host control bits
  input  wire logic [NUM_SRC-1:0]    irq_enable,
  input  wire logic                  host_clear_strobe,
  input  wire logic [NUM_SRC-1:0]    host_clear_mask,
  input  wire logic [NUM_GPIO-1:0]   gpio_dir,
  input  wire logic [NUM_GPIO-1:0]   gpio_out_value,
  input  wire logic [NUM_GPIO-1:0]   gpio_rise_sel,
  // display-channel requests
  input  wire logic                  host_ddc_req,
  input  wire logic                  engine_ddc_req,
  input  wire logic                  host_ddc_start,
  input  wire logic [DDC_ADDR_W-1:0] host_ddc_addr,
  input  wire logic [DDC_OFS_W-1:0]  host_ddc_offset,
  input  wire logic [DDC_CNT_W-1:0]  host_ddc_count,
  // status and interrupt
  output logic                       irq_out,
  output logic [NUM_SRC-1:0]         pending,
  output logic [NUM_GPIO-1:0]        gpio_level,
  output logic                       monitor_present,
  output logic                       edid_readable,
  // pins
  output logic [NUM_GPIO-1:0]        gpio_pin_out,
  output logic [NUM_GPIO-1:0]        gpio_pin_oe_n,
  // display-channel master
  output logic                       ddc_grant_host,
  output logic                       ddc_grant_engine,
  output logic                       ddc_go,
  output logic [DDC_ADDR_W-1:0]      ddc_target_addr,
  output logic [DDC_OFS_W-1:0]       ddc_start_offset,
  output logic [DDC_CNT_W-1:0]       ddc_byte_count
);

  typedef struct packed {
    logic [SYNC_W-1:0]     s1;
    logic [SYNC_W-1:0]     s2;
    logic [SYNC_W-1:0]     prev;
    logic [FIFO_ST_W-1:0]  fifo_prev;
    logic [NUM_SRC-1:0]    pend;
    logic                  irq;
    logic [NUM_GPIO-1:0]   gpio_out;
    logic [NUM_GPIO-1:0]   gpio_oe_n;
    logic [NUM_GPIO-1:0]   gpio_level;
    logic                  mon;
    logic                  edid;
    arb_t                  arb;
    logic                  gnt_host;
    logic                  gnt_engine;
    logic                  go;
    logic [DDC_ADDR_W-1:0] addr;
    logic [DDC_OFS_W-1:0]  ofs;
    logic [DDC_CNT_W-1:0]  cnt;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb begin
    logic [NUM_SRC-1:0] set;
    logic [NUM_SRC-1:0] clr;
    logic               rise;
    logic               fall;
    set  = '0;
    clr  = '0;
    rise = 1'b0;
    fall = 1'b0;
    s_d  = s_q;
    if (clk_en) begin
      // s1 feeds only s2; all pin detection looks at s2 against prev
      s_d.s1   = {gpio_pin_in, vsync_in, rx_sense_in, hot_plug_sense_in};
      s_d.s2   = s_q.s1;
      s_d.prev = s_q.s2;
      // monitor detect stays live in power-down; this logic only needs the slow clock
      set[SRC_MONITOR] = (s_q.s2[SYN_HPD] ^ s_q.prev[SYN_HPD])
                       | (s_q.s2[SYN_RXS] ^ s_q.prev[SYN_RXS]);
      if (!power_down) begin
        set[SRC_VSYNC]    = s_q.s2[SYN_VS] & ~s_q.prev[SYN_VS];
        set[SRC_AUDIO]    = audio_fmt_err;
        set[SRC_AUTH]     = auth_err;
        set[SRC_FIFO_CHG] = ddc_fifo_status != s_q.fifo_prev;
        set[SRC_DDC_DONE] = ddc_xfer_done;
        set[SRC_DDC_FULL] = ddc_fifo_full;
        for (int i = 0; i < NUM_GPIO; i++) begin
          rise = s_q.s2[SYN_GPIO+i] & ~s_q.prev[SYN_GPIO+i];
          fall = ~s_q.s2[SYN_GPIO+i] & s_q.prev[SYN_GPIO+i];
          set[SRC_GPIO+i] = ~gpio_dir[i] & (gpio_rise_sel[i] ? rise : fall);
        end
      end
      s_d.fifo_prev = ddc_fifo_status;
      if (host_clear_strobe) begin
        clr = host_clear_mask;
      end
      // set wins over clear so an event in the clear cycle survives
      s_d.pend = (s_q.pend & ~clr) | set;
      s_d.irq  = |(s_d.pend & irq_enable);
      s_d.gpio_out   = gpio_out_value;
      s_d.gpio_oe_n  = ~gpio_dir;
      s_d.gpio_level = s_q.s2[SYN_GPIO +: NUM_GPIO];
      s_d.mon  = s_q.s2[SYN_HPD] | s_q.s2[SYN_RXS];
      s_d.edid = s_q.s2[SYN_HPD];
      // engine wins a tie; a grant is kept until its request drops
      unique case (s_q.arb)
        ARB_IDLE: begin
          if (engine_ddc_req) begin
            s_d.arb = ARB_ENGINE;
          end else if (host_ddc_req) begin
            s_d.arb = ARB_HOST;
          end
        end
        ARB_HOST: begin
          if (!host_ddc_req) begin
            s_d.arb = ARB_IDLE;
          end
        end
        ARB_ENGINE: begin
          if (!engine_ddc_req) begin
            s_d.arb = ARB_IDLE;
          end
        end
        default: s_d.arb = ARB_IDLE;
      endcase
      s_d.gnt_host   = s_d.arb == ARB_HOST;
      s_d.gnt_engine = s_d.arb == ARB_ENGINE;
      // a start without the grant is dropped, not queued
      s_d.go = 1'b0;
      if (s_q.gnt_host && host_ddc_start) begin
        s_d.go   = 1'b1;
        s_d.addr = host_ddc_addr;
        s_d.ofs  = host_ddc_offset;
        s_d.cnt  = host_ddc_count;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q           <= '0;
      s_q.pend      <= PEND_RST;
      s_q.gpio_out  <= GPIO_OUT_RST;
      s_q.gpio_oe_n <= GPIO_OEN_RST;
      s_q.arb       <= ARB_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a field of the registered state
  assign irq_out          = s_q.irq;
  assign pending          = s_q.pend;
  assign gpio_level       = s_q.gpio_level;
  assign monitor_present  = s_q.mon;
  assign edid_readable    = s_q.edid;
  assign gpio_pin_out     = s_q.gpio_out;
  assign gpio_pin_oe_n    = s_q.gpio_oe_n;
  assign ddc_grant_host   = s_q.gnt_host;
  assign ddc_grant_engine = s_q.gnt_engine;
  assign ddc_go           = s_q.go;
  assign ddc_target_addr  = s_q.addr;
  assign ddc_start_offset = s_q.ofs;
  assign ddc_byte_count   = s_q.cnt;

  property p_gpio_drive;
    @(posedge clock) disable iff (rst)
      clk_en |=> (gpio_pin_oe_n == ~$past(gpio_dir)) && (gpio_pin_out == $past(gpio_out_value));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive mismatch");

  property p_gpio_level;
    @(posedge clock) disable iff (rst)
      clk_en ##1 clk_en ##1 clk_en |=> gpio_level == $past(gpio_pin_in, 3);
  endproperty
  a_gpio_level: assert property (p_gpio_level) else $error("gpio level not sampled");

  // rising edges on input pins that ask for them, any pin, so the check is not tied to one lane
  logic [NUM_GPIO-1:0] gpio_rise_hit;
  assign gpio_rise_hit = ~gpio_dir & gpio_rise_sel
                       & s_q.s2[SYN_GPIO +: NUM_GPIO] & ~s_q.prev[SYN_GPIO +: NUM_GPIO];

  property p_gpio_edge;
    @(posedge clock) disable iff (rst)
      clk_en && !power_down && (|gpio_rise_hit)
        |=> (pending[SRC_GPIO +: NUM_GPIO] & $past(gpio_rise_hit)) == $past(gpio_rise_hit);
  endproperty
  a_gpio_edge: assert property (p_gpio_edge) else $error("gpio edge lost");

  property p_set_wins;
    @(posedge clock) disable iff (rst)
      clk_en && !power_down && audio_fmt_err && host_clear_strobe |=> pending[SRC_AUDIO];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in clear cycle");

  property p_monitor_pd;
    @(posedge clock) disable iff (rst)
      clk_en && (s_q.s2[SYN_RXS] != s_q.prev[SYN_RXS]) |=> pending[SRC_MONITOR];
  endproperty
  a_monitor_pd: assert property (p_monitor_pd) else $error("monitor change lost");

  property p_vsync;
    @(posedge clock) disable iff (rst)
      clk_en && !power_down && s_q.s2[SYN_VS] && !s_q.prev[SYN_VS] |=> pending[SRC_VSYNC];
  endproperty
  a_vsync: assert property (p_vsync) else $error("vsync event lost");

  property p_fifo_chg;
    @(posedge clock) disable iff (rst)
      clk_en && !power_down && $past(clk_en) && ddc_fifo_status != $past(ddc_fifo_status)
        |=> pending[SRC_FIFO_CHG];
  endproperty
  a_fifo_chg: assert property (p_fifo_chg) else $error("fifo change lost");

  property p_irq_cause;
    @(posedge clock) disable iff (rst)
      clk_en |=> irq_out == |(pending & $past(irq_enable));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt not tied to pending");

  property p_one_grant;
    @(posedge clock) disable iff (rst)
      !(ddc_grant_host && ddc_grant_engine);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants at once");

  property p_engine_grant;
    @(posedge clock) disable iff (rst)
      clk_en && engine_ddc_req && !ddc_grant_host |=> ddc_grant_engine;
  endproperty
  a_engine_grant: assert property (p_engine_grant) else $error("engine not granted");

  property p_edid;
    @(posedge clock) disable iff (rst)
      clk_en |=> edid_readable == $past(s_q.s2[SYN_HPD]);
  endproperty
  a_edid: assert property (p_edid) else $error("edid readable wrong");

endmodule
`default_nettype wire

// ### rtl/tx_event_pkg.sv
`default_nettype none
package tx_event_pkg;

  // widths
  localparam int NUM_GPIO   = 4;
  localparam int NUM_SRC    = 11;
  localparam int SYNC_W     = 3 + NUM_GPIO;
  localparam int FIFO_ST_W  = 4;
  localparam int DDC_ADDR_W = 7;
  localparam int DDC_OFS_W  = 8;
  localparam int DDC_CNT_W  = 10;

  // positions in the synchroniser vector
  localparam int SYN_HPD  = 0;
  localparam int SYN_RXS  = 1;
  localparam int SYN_VS   = 2;
  localparam int SYN_GPIO = 3;

  // positions in the pending / enable / clear vectors
  localparam int SRC_MONITOR  = 0;
  localparam int SRC_VSYNC    = 1;
  localparam int SRC_AUDIO    = 2;
  localparam int SRC_AUTH     = 3;
  localparam int SRC_FIFO_CHG = 4;
  localparam int SRC_DDC_DONE = 5;
  localparam int SRC_DDC_FULL = 6;
  localparam int SRC_GPIO     = 7;

  // reset values
  localparam logic [NUM_SRC-1:0]  PEND_RST    = 11'h000;
  localparam logic [NUM_GPIO-1:0] GPIO_OUT_RST = 4'h0;
  localparam logic [NUM_GPIO-1:0] GPIO_OEN_RST = 4'hf;

  typedef enum logic [1:0] {
    ARB_IDLE   = 2'b00,
    ARB_HOST   = 2'b01,
    ARB_ENGINE = 2'b10
  } arb_t;

endpackage
`default_nettype wire

// ### tb/tx_event_sync_source.sv
`timescale 1ns/1ps
`default_nettype none
module tx_event_sync_source (
  // frame control
  input  wire logic run,
  // sync pin toward the transmitter
  output logic      vsync_pin
);
  logic link_clk;
  // phase offset keeps link clock edges 1ns after block clock edges, at a fixed 8:1 period ratio
  initial begin
    link_clk = 1'b0;
    #5;
    forever #32 link_clk = ~link_clk;
  end
  // sync only moves inside a frame and rests low between frames
  initial begin
    vsync_pin = 1'b0;
    forever @(posedge link_clk) vsync_pin <= run ? ~vsync_pin : 1'b0;
  end
endmodule
`default_nettype wire

// ### tb/tx_event_interrupt_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tx_event_interrupt_logic_bench;
  import tx_event_pkg::*;
  logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, hot_plug_sense_in, rx_sense_in, power_down, link_run;
  logic host_clear_strobe, host_ddc_req, engine_ddc_req, host_ddc_start, irq_out, monitor_present;
  logic edid_readable, ddc_grant_host, ddc_grant_engine, ddc_go;
  wire logic vsync_in, audio_fmt_err, auth_err, ddc_xfer_done, ddc_fifo_full;
  logic [3:0] ev;
  logic [NUM_GPIO-1:0] gpio_pin_in, gpio_dir, gpio_out_value, gpio_rise_sel, gpio_level, gpio_pin_out, gpio_pin_oe_n;
  logic [NUM_SRC-1:0] irq_enable, host_clear_mask, pending;
  logic [FIFO_ST_W-1:0] ddc_fifo_status;
  logic [DDC_ADDR_W-1:0] host_ddc_addr, ddc_target_addr;
  logic [DDC_OFS_W-1:0] host_ddc_offset, ddc_start_offset;
  logic [DDC_CNT_W-1:0] host_ddc_count, ddc_byte_count;
  int errors = 0, total_checks = 0, cycles = 0;
  int src [4] = '{SRC_AUDIO, SRC_AUTH, SRC_DDC_DONE, SRC_DDC_FULL};
  assign {ddc_fifo_full, ddc_xfer_done, auth_err, audio_fmt_err} = ev;

  tx_event_sync_source i_src (.run(link_run), .vsync_pin(vsync_in));
  tx_event_interrupt_logic i_dut (.clock, .rst, .clk_en, .hot_plug_sense_in, .rx_sense_in, .vsync_in,
    .gpio_pin_in, .power_down, .audio_fmt_err, .auth_err, .ddc_fifo_status, .ddc_xfer_done, .ddc_fifo_full,
    .irq_enable, .host_clear_strobe, .host_clear_mask, .gpio_dir, .gpio_out_value, .gpio_rise_sel,
    .host_ddc_req, .engine_ddc_req, .host_ddc_start, .host_ddc_addr, .host_ddc_offset, .host_ddc_count,
    .irq_out, .pending, .gpio_level, .monitor_present, .edid_readable, .gpio_pin_out, .gpio_pin_oe_n,
    .ddc_grant_host, .ddc_grant_engine, .ddc_go, .ddc_target_addr, .ddc_start_offset, .ddc_byte_count);

  always #4 clock = ~clock;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // write-1-to-clear of every flag, one strobe cycle
  task automatic clear_all();
    @(posedge clock);
    host_clear_strobe <= 1'b1;
    host_clear_mask <= 11'h7ff;
    @(posedge clock);
    host_clear_strobe <= 1'b0;
    edges(1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // run is under two hundred cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    {hot_plug_sense_in, rx_sense_in, power_down, link_run, host_clear_strobe, ev} = '0;
    {host_ddc_req, engine_ddc_req, host_ddc_start, gpio_pin_in, gpio_dir, gpio_out_value} = '0;
    {gpio_rise_sel, irq_enable, host_clear_mask, ddc_fifo_status} = '0;
    {host_ddc_addr, host_ddc_offset, host_ddc_count} = '0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    edges(2);
    chk("pending", pending, 16'h0);
    chk("oe_n", gpio_pin_oe_n, 16'hf);
    @(posedge clock) ev <= 4'h1;
    @(posedge clock) ev <= 4'h0;
    edges(1);
    chk("masked irq", irq_out, 16'h0);
    @(posedge clock) irq_enable <= 11'h7ff;
    edges(2);
    chk("irq", irq_out, 16'h1);
    clear_all();
    for (int k = 0; k < 4; k++) begin
      @(posedge clock) ev <= 4'(1 << k);
      @(posedge clock) ev <= 4'h0;
      edges(1);
      chk("event", pending, 16'(NUM_SRC'(1) << src[k]));
      chk("irq", irq_out, 16'h1);
      clear_all();
      chk("cleared", {irq_out, pending}, 16'h0);
    end
    // an event in the clear cycle must survive the clear
    @(posedge clock) {host_clear_strobe, host_clear_mask, ev} <= {1'b1, 11'h7ff, 4'h1};
    @(posedge clock) {host_clear_strobe, ev} <= 5'h00;
    edges(1);
    chk("set wins", pending, 16'h4);
    clear_all();
    @(posedge clock) ddc_fifo_status <= 4'h5;
    edges(2);
    chk("fifo change", pending, 16'h10);
    // with clk_en low neither an event nor a clear may touch the flags
    @(posedge clock) {clk_en, host_clear_strobe, host_clear_mask, ev} <= {2'b01, 11'h7ff, 4'h1};
    @(posedge clock) {clk_en, host_clear_strobe, ev} <= 6'h20;
    edges(1);
    chk("frozen", {irq_out, pending}, 16'h810);
    clear_all();
    $display("test events done");
    @(posedge clock) {power_down, hot_plug_sense_in, ev} <= 6'h31;
    @(posedge clock) ev <= 4'h0;
    edges(5);
    chk("power down", pending, 16'h1);
    chk("edid", {edid_readable, monitor_present}, 16'h3);
    // only receiver sense moves here, so the monitor event must come from it alone
    @(posedge clock) {power_down, hot_plug_sense_in, rx_sense_in} <= 3'h3;
    clear_all();
    edges(5);
    chk("rx sense", pending, 16'h1);
    chk("edid", {edid_readable, monitor_present}, 16'h3);
    clear_all();
    $display("test monitor done");
    @(posedge clock) {gpio_dir, gpio_out_value, gpio_rise_sel} <= 12'h512;
    edges(2);
    chk("pin out", gpio_pin_out & 4'h5, 16'h1);
    chk("oe_n", gpio_pin_oe_n, 16'ha);
    @(posedge clock) gpio_pin_in <= 4'h2;
    edges(5);
    chk("rise", pending, 16'h100);
    chk("level", gpio_level & 4'ha, 16'h2);
    clear_all();
    @(posedge clock) gpio_pin_in <= 4'hb;
    edges(5);
    chk("no event", pending, 16'h0);
    @(posedge clock) gpio_pin_in <= 4'h2;
    edges(5);
    chk("fall", pending, 16'h400);
    clear_all();
    $display("test pins done");
    @(posedge clock) {host_ddc_req, engine_ddc_req} <= 2'h3;
    edges(2);
    chk("tie", {ddc_grant_host, ddc_grant_engine}, 16'h1);
    @(posedge clock) engine_ddc_req <= 1'b0;
    edges(4);
    chk("handover", {ddc_grant_host, ddc_grant_engine}, 16'h2);
    @(posedge clock) {host_ddc_start, host_ddc_addr, host_ddc_offset, host_ddc_count} <= {1'b1, 7'h50, 8'h10, 10'h080};
    @(posedge clock) host_ddc_start <= 1'b0;
    #2;
    chk("go", ddc_go, 16'h1);
    chk("program", {ddc_target_addr, ddc_start_offset}, 16'h5010);
    chk("count", ddc_byte_count, 16'h080);
    edges(1);
    chk("go pulse", ddc_go, 16'h0);
    $display("test channel done");
    @(posedge clock) link_run <= 1'b1;
    edges(40);
    chk("vsync", pending[SRC_VSYNC], 16'h1);
    @(posedge clock) link_run <= 1'b0;
    $display("test sync done");
    complete_run();
  end
endmodule
`default_nettype wire
